// ==== design/i2ra_defines.svh ====
/*
 * Constants of the serial register access target: bus addresses, codes,
 * field widths and reset values.
 * Assumes it is included by its bare name before any user of the macros.
 */
`ifndef I2RA_DEFINES_SVH
`define I2RA_DEFINES_SVH

`define I2RA_ADDR_SEL1 7'h48
`define I2RA_ADDR_SEL0 7'h40
`define I2RA_HS_CODE_TOP 5'h01
`define I2RA_GENERAL_CALL 8'h00
`define I2RA_PTR_RST 8'h00
`define I2RA_BYTE_BITS 4'h8
`define I2RA_LAST_TX_BIT 4'h7

`endif

// ==== design/i2ra_pkg.sv ====
/*
 * Types shared by the serial register access target.
 * Assumes nothing of its surroundings.
 */
package i2ra_pkg;

    typedef enum logic [9:0] {
        ST_IDLE     = 10'h001,
        ST_ADDR     = 10'h002,
        ST_ACK_ADDR = 10'h004,
        ST_PTR      = 10'h008,
        ST_ACK_PTR  = 10'h010,
        ST_WDATA    = 10'h020,
        ST_ACK_W    = 10'h040,
        ST_RDATA    = 10'h080,
        ST_MACK     = 10'h100,
        ST_IGNORE   = 10'h200
    } i2ra_state_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
        logic we;
    } i2ra_wr_type;

endpackage

// ==== design/i2ra_target.sv ====
/*
 * Target end of a two-wire serial register access link with an 8-bit
 * register pointer, sequential access and high-speed code detection.
 * Assumes clk is much faster than the link clock, SCL and SDA come straight
 * from pins, and the register store answers reg_rdata for reg_addr within
 * a few clk cycles.
 */
`include "i2ra_defines.svh"
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Acknowledge own 7-bit address with write bit by pulling SDA low.
// - Acknowledge the register pointer byte.
// - Single write data byte may be acknowledged or not; we acknowledge it.
// - Commit written byte on first rising SDA edge after its acknowledge clock.
// - Sequential write: acknowledge and commit each byte to successive registers.
// - Stop restores slow input filters; repeated start leaves them alone.
// - After read address acknowledge, send eight bits MSB first from pointer.
// - Sequential read: master acknowledge fetches next byte, refusal ends.
// - Stop leaves the register pointer unchanged.
// - Snapshot timekeeping buffers during the read address phase.
// - Refuse the high-speed code and switch filters to high speed.
// - High speed lasts across repeated starts until the next stop.
// - Answer 0x48 or 0x40 by select strap; ignore other addresses.
// - Acknowledge every pointer value of the 8-bit space.
// - Never hold SCL low.
// - Refuse the general call address.
module i2ra_target (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic addr_sel,
    output logic [7:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    output i2ra_pkg::i2ra_wr_type reg_wr,
    output logic snap,
    output logic hs_mode
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic scl_s1, scl_s2, scl_s3;
    logic sda_s1, sda_s2, sda_s3;
    logic sel_s1, sel_s2;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_s3 <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_s3 <= 1'b1;
            sel_s1 <= 1'b0;
            sel_s2 <= 1'b0;
        end else if (ce) begin
            scl_s1 <= scl_i;
            scl_s2 <= scl_s1;
            scl_s3 <= scl_s2;
            sda_s1 <= sda_i;
            sda_s2 <= sda_s1;
            sda_s3 <= sda_s2;
            sel_s1 <= addr_sel;
            sel_s2 <= sel_s1;
        end
    end

    logic scl_rise, scl_fall, sda_rise, start_cond, stop_cond;
    logic [6:0] my_addr;
    assign scl_rise = scl_s2 & ~scl_s3;
    assign scl_fall = ~scl_s2 & scl_s3;
    assign sda_rise = sda_s2 & ~sda_s3;
    assign start_cond = scl_s2 & scl_s3 & ~sda_s2 & sda_s3;
    assign stop_cond = scl_s2 & scl_s3 & sda_s2 & ~sda_s3;
    assign my_addr = sel_s2 ? `I2RA_ADDR_SEL1 : `I2RA_ADDR_SEL0;

    // ****************************************************************
    // Protocol engine
    // ****************************************************************
    i2ra_pkg::i2ra_state_type st, next_st;
    logic [3:0] cnt, next_cnt;
    logic [7:0] shift, next_shift;
    logic [7:0] ptr, next_ptr;
    logic rd, next_rd;
    logic m_ack, next_m_ack;
    logic pend, next_pend;
    i2ra_pkg::i2ra_wr_type pend_wr, next_pend_wr;
    i2ra_pkg::i2ra_wr_type next_reg_wr;
    logic next_sda_oe, next_snap, next_hs_mode;

    always_comb begin
        next_st = st;
        next_cnt = cnt;
        next_shift = shift;
        next_ptr = ptr;
        next_rd = rd;
        next_m_ack = m_ack;
        next_pend = pend;
        next_pend_wr = pend_wr;
        next_reg_wr = reg_wr;
        next_reg_wr.we = 1'b0;
        next_sda_oe = sda_oe;
        next_snap = 1'b0;
        next_hs_mode = hs_mode;
        // Held write lands on the first SDA rise, a stop's rise included
        if (pend && sda_rise) begin
            next_reg_wr = pend_wr;
            next_reg_wr.we = 1'b1;
            next_pend = 1'b0;
        end
        if (start_cond) begin
            // Repeated start keeps the filter setting
            next_st = i2ra_pkg::ST_ADDR;
            next_cnt = 4'h0;
            next_sda_oe = 1'b0;
        end else if (stop_cond) begin
            next_st = i2ra_pkg::ST_IDLE; // Pointer untouched
            next_sda_oe = 1'b0;
            next_hs_mode = 1'b0;
        end else begin
            case (st)
                i2ra_pkg::ST_ADDR, i2ra_pkg::ST_PTR, i2ra_pkg::ST_WDATA: begin
                    if (scl_rise && cnt != `I2RA_BYTE_BITS) begin
                        next_shift = {shift[6:0], sda_s2};
                        next_cnt = cnt + 4'h1;
                    end else if (scl_fall && cnt == `I2RA_BYTE_BITS) begin
                        next_cnt = 4'h0;
                        if (st == i2ra_pkg::ST_ADDR) begin
                            if (shift[7:3] == `I2RA_HS_CODE_TOP) begin
                                next_hs_mode = 1'b1;
                                next_st = i2ra_pkg::ST_IGNORE;
                            end else if (shift != `I2RA_GENERAL_CALL && shift[7:1] == my_addr) begin
                                next_sda_oe = 1'b1;
                                next_rd = shift[0];
                                next_snap = shift[0];
                                next_st = i2ra_pkg::ST_ACK_ADDR;
                            end else begin
                                next_st = i2ra_pkg::ST_IGNORE;
                            end
                        end else if (st == i2ra_pkg::ST_PTR) begin
                            next_ptr = shift; // Any pointer value is taken
                            next_sda_oe = 1'b1;
                            next_st = i2ra_pkg::ST_ACK_PTR;
                        end else begin
                            next_sda_oe = 1'b1;
                            next_st = i2ra_pkg::ST_ACK_W;
                        end
                    end
                end
                i2ra_pkg::ST_ACK_ADDR: begin
                    if (scl_fall) begin
                        if (rd) begin
                            next_shift = reg_rdata;
                            next_sda_oe = ~reg_rdata[7];
                            next_st = i2ra_pkg::ST_RDATA;
                        end else begin
                            next_sda_oe = 1'b0;
                            next_st = i2ra_pkg::ST_PTR;
                        end
                    end
                end
                i2ra_pkg::ST_ACK_PTR: begin
                    if (scl_fall) begin
                        next_sda_oe = 1'b0;
                        next_st = i2ra_pkg::ST_WDATA;
                    end
                end
                i2ra_pkg::ST_ACK_W: begin
                    if (scl_fall) begin
                        // A byte still waiting for an SDA rise is flushed, not lost
                        if (next_pend) begin
                            next_reg_wr = pend_wr;
                            next_reg_wr.we = 1'b1;
                        end
                        next_pend = 1'b1;
                        next_pend_wr = '{addr: ptr, data: shift, we: 1'b1};
                        next_ptr = ptr + 8'h01;
                        next_sda_oe = 1'b0;
                        next_st = i2ra_pkg::ST_WDATA;
                    end
                end
                i2ra_pkg::ST_RDATA: begin
                    if (scl_fall) begin
                        if (cnt == `I2RA_LAST_TX_BIT) begin
                            next_sda_oe = 1'b0;
                            next_ptr = ptr + 8'h01;
                            next_st = i2ra_pkg::ST_MACK;
                        end else begin
                            next_cnt = cnt + 4'h1;
                            next_shift = {shift[6:0], 1'b0};
                            next_sda_oe = ~shift[6];
                        end
                    end
                end
                i2ra_pkg::ST_MACK: begin
                    if (scl_rise) begin
                        next_m_ack = ~sda_s2;
                    end else if (scl_fall) begin
                        next_cnt = 4'h0;
                        if (m_ack) begin
                            next_shift = reg_rdata;
                            next_sda_oe = ~reg_rdata[7];
                            next_st = i2ra_pkg::ST_RDATA;
                        end else begin
                            next_st = i2ra_pkg::ST_IGNORE;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= i2ra_pkg::ST_IDLE;
            cnt <= 4'h0;
            shift <= 8'h00;
            ptr <= `I2RA_PTR_RST;
            rd <= 1'b0;
            m_ack <= 1'b0;
            pend <= 1'b0;
            pend_wr <= '0;
            reg_wr <= '0;
            sda_oe <= 1'b0;
            sda_o <= 1'b0;
            snap <= 1'b0;
            hs_mode <= 1'b0;
        end else if (ce) begin
            st <= next_st;
            cnt <= next_cnt;
            shift <= next_shift;
            ptr <= next_ptr;
            rd <= next_rd;
            m_ack <= next_m_ack;
            pend <= next_pend;
            pend_wr <= next_pend_wr;
            reg_wr <= next_reg_wr;
            sda_oe <= next_sda_oe;
            sda_o <= 1'b0;
            snap <= next_snap;
            hs_mode <= next_hs_mode;
        end
    end

    // No SCL driver exists at all, so the clock is never stretched
    assign reg_addr = ptr;

    // ****************************************************************
    // Checks
    // ****************************************************************
    logic addr_done;
    assign addr_done = ce && !start_cond && !stop_cond && st == i2ra_pkg::ST_ADDR
        && scl_fall && cnt == `I2RA_BYTE_BITS;

    property p_addr_ack;
        @(posedge clk) disable iff (!rst_n || !ce)
        (addr_done && shift[7:1] == my_addr && shift != `I2RA_GENERAL_CALL)
            |=> sda_oe && st == i2ra_pkg::ST_ACK_ADDR;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("own address not acknowledged");

    property p_ptr_ack;
        @(posedge clk) disable iff (!rst_n || !ce)
        st == i2ra_pkg::ST_ACK_PTR |-> sda_oe;
    endproperty
    a_ptr_ack: assert property (p_ptr_ack) else $error("pointer byte not acknowledged");

    property p_commit;
        @(posedge clk) disable iff (!rst_n || !ce)
        (pend && sda_rise) |=> reg_wr.we && reg_wr == $past(pend_wr);
    endproperty
    a_commit: assert property (p_commit) else $error("held write not committed on SDA rise");

    property p_stop_filter;
        @(posedge clk) disable iff (!rst_n || !ce)
        stop_cond |=> !hs_mode && ptr == $past(ptr);
    endproperty
    a_stop_filter: assert property (p_stop_filter) else $error("stop handling wrong");

    property p_hs_code;
        @(posedge clk) disable iff (!rst_n || !ce)
        (addr_done && shift[7:3] == `I2RA_HS_CODE_TOP) |=> hs_mode && !sda_oe;
    endproperty
    a_hs_code: assert property (p_hs_code) else $error("high-speed code mishandled");

    property p_foreign;
        @(posedge clk) disable iff (!rst_n || !ce)
        (addr_done && (shift[7:1] != my_addr || shift == `I2RA_GENERAL_CALL))
            |=> !sda_oe ##1 !sda_oe;
    endproperty
    a_foreign: assert property (p_foreign) else $error("foreign or general call acknowledged");

    property p_snap;
        @(posedge clk) disable iff (!rst_n || !ce)
        (addr_done && shift[7:1] == my_addr && shift[0]) |=> snap ##1 !snap;
    endproperty
    a_snap: assert property (p_snap) else $error("snapshot pulse missing");

    property p_ptr_step;
        @(posedge clk) disable iff (!rst_n || !ce)
        (st == i2ra_pkg::ST_ACK_W && next_st == i2ra_pkg::ST_WDATA) |=> ptr == $past(ptr) + 8'h01;
    endproperty
    a_ptr_step: assert property (p_ptr_step) else $error("pointer did not step");

    property p_drive_only;
        @(posedge clk) disable iff (!rst_n || !ce)
        sda_oe |-> st inside {i2ra_pkg::ST_ACK_ADDR, i2ra_pkg::ST_ACK_PTR,
            i2ra_pkg::ST_ACK_W, i2ra_pkg::ST_RDATA};
    endproperty
    a_drive_only: assert property (p_drive_only) else $error("SDA driven outside a slot");

endmodule
`default_nettype wire

// ==== sim/i2ra_master_model.sv ====
/*
 * Bus controller model for the serial register access target: makes the
 * link clock and pulls the data line low, one 200 ns bit at a time.
 * Assumes the bench resolves the data line with a pull-up.
 */
`timescale 1ns/1ps
`default_nettype none
module i2ra_master_model (
    output logic scl,
    output logic sda_pull,
    input wire logic sda
);
    // Link clock idles high between frames
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    // Long low phase: the target answers about 3 clk after the fall
    task automatic bit_io(input logic b, output logic r);
        #70 sda_pull = ~b;
        #70 scl = 1'b1;
        #30 r = sda;
        #30 scl = 1'b0;
    endtask

    // Start or repeated start, always at the slow rate
    task automatic start;
        if (scl === 1'b0) begin
            #100 sda_pull = 1'b0;
            #100 scl = 1'b1;
        end
        #100 sda_pull = 1'b1;
        #100 scl = 1'b0;
    endtask

    task automatic stop;
        #100 sda_pull = 1'b1;
        #100 scl = 1'b1;
        #100 sda_pull = 1'b0;
        #100;
    endtask

    // Address, pointer or data; releases the line on the ack clock
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    // Acknowledge asks for more, refusal ends the read
    task automatic rbyte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(~ack, r);
    endtask
endmodule
`default_nettype wire

// ==== sim/i2ra_target_test.sv ====
/*
 * Self-checking bench of the serial register access target.
 * Assumes a 40 MHz clock and a bench-held register store behind the ports.
 */
`timescale 1ns/1ps
`default_nettype none
module i2ra_target_test;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic addr_sel = 1'b1;
    logic scl;
    logic m_pull;
    logic sda_o;
    logic sda_oe;
    logic sda_line;
    logic [7:0] reg_addr;
    logic [7:0] reg_rdata = 8'h00;
    i2ra_pkg::i2ra_wr_type reg_wr;
    logic snap;
    logic hs_mode;
    logic [7:0] mem [256];
    logic [15:0] wq [$];
    int n_snap = 0;
    int n_fail = 0;
    int checks_done = 0;
    logic a;
    logic [7:0] d;

    always #12.5 clk = ~clk;
    // Open-drain wire with pull-up
    assign sda_line = (sda_oe | m_pull) ? 1'b0 : 1'b1;

    i2ra_master_model M (.scl(scl), .sda_pull(m_pull), .sda(sda_line));

    i2ra_target DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe(sda_oe), .addr_sel(addr_sel), .reg_addr(reg_addr),
        .reg_rdata(reg_rdata), .reg_wr(reg_wr), .snap(snap), .hs_mode(hs_mode));

    // ****************************
    // Register store and monitors
    // ****************************
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = i[7:0] ^ 8'h5a;
        end
    end
    always @(posedge clk) begin
        if (reg_wr.we === 1'b1) begin
            mem[reg_wr.addr] <= reg_wr.data;
            wq.push_back({reg_wr.addr, reg_wr.data});
        end
        if (snap === 1'b1) begin
            n_snap++;
        end
        reg_rdata <= mem[reg_addr];
    end

    // ****************************
    // Checking helpers
    // ****************************
    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic send(input logic [7:0] v, input logic exp_ack);
        M.wbyte(v, a);
        cmp("ack", {15'h0, exp_ack}, {15'h0, a});
    endtask

    task automatic wr_chk(input logic [15:0] e);
        cmp("write", e, (wq.size() > 0) ? wq.pop_front() : 16'hxxxx);
    endtask

    task automatic settle;
        repeat (10) @(posedge clk);
    endtask

    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ****************************
    // Scenarios
    // ****************************
    task automatic t_write_single;
        M.start();
        send(8'h90, 1'b1);
        send(8'h10, 1'b1);
        send(8'ha5, 1'b1);
        cmp("held", 16'h0, 16'(wq.size()));
        M.stop();
        settle();
        wr_chk(16'h10a5);
        cmp("hs", 16'h0, {15'h0, hs_mode});
        $display("test write_single done");
    endtask

    task automatic t_write_seq;
        M.start();
        send(8'h90, 1'b1);
        send(8'hfe, 1'b1);
        send(8'h11, 1'b1);
        send(8'h22, 1'b1);
        send(8'h33, 1'b1);
        M.stop();
        settle();
        wr_chk(16'hfe11);
        wr_chk(16'hff22);
        wr_chk(16'h0033);
        $display("test write_seq done");
    endtask

    task automatic t_read;
        M.start();
        send(8'h90, 1'b1);
        send(8'h20, 1'b1);
        n_snap = 0;
        M.start();
        send(8'h91, 1'b1);
        cmp("snap", 16'h1, 16'(n_snap));
        M.rbyte(1'b1, d);
        cmp("rd0", 16'h007a, {8'h0, d});
        M.rbyte(1'b1, d);
        cmp("rd1", 16'h007b, {8'h0, d});
        M.rbyte(1'b0, d);
        cmp("rd2", 16'h0078, {8'h0, d});
        M.stop();
        settle();
        cmp("ptr", 16'h0023, {8'h0, reg_addr});
        M.start();
        send(8'h91, 1'b1);
        M.rbyte(1'b0, d);
        cmp("rd3", 16'h0079, {8'h0, d});
        M.stop();
        settle();
        $display("test read done");
    endtask

    task automatic t_refuse;
        M.start();
        send(8'h92, 1'b0);
        send(8'h55, 1'b0);
        M.stop();
        M.start();
        send(8'h00, 1'b0);
        M.stop();
        @(posedge clk);
        addr_sel <= 1'b0;
        settle();
        M.start();
        send(8'h90, 1'b0);
        M.start();
        send(8'h80, 1'b1);
        send(8'h30, 1'b1);
        send(8'h44, 1'b1);
        M.stop();
        settle();
        wr_chk(16'h3044);
        cmp("wr_cnt", 16'h0, 16'(wq.size()));
        // Clock enable low freezes the target: its own address goes unanswered
        ce <= 1'b0;
        M.start();
        send(8'h80, 1'b0);
        M.stop();
        @(posedge clk);
        ce <= 1'b1;
        settle();
        cmp("frozen_wr", 16'h0, 16'(wq.size()));
        cmp("sda_o", 16'h0, {15'h0, sda_o});
        @(posedge clk);
        addr_sel <= 1'b1;
        settle();
        $display("test refuse done");
    endtask

    task automatic t_high_speed;
        M.start();
        send(8'h0b, 1'b0);
        settle();
        cmp("hs_on", 16'h1, {15'h0, hs_mode});
        M.start();
        send(8'h90, 1'b1);
        send(8'h40, 1'b1);
        send(8'h66, 1'b1);
        M.start();
        settle();
        cmp("hs_sr", 16'h1, {15'h0, hs_mode});
        wr_chk(16'h4066);
        M.stop();
        settle();
        cmp("hs_off", 16'h0, {15'h0, hs_mode});
        $display("test high_speed done");
    endtask

    // ****************************
    // Main sequence and watchdog
    // ****************************
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        t_write_single();
        t_write_seq();
        t_read();
        t_refuse();
        t_high_speed();
        end_sim();
    end

    // Whole run is about 60 us of link traffic
    initial begin
        #600000;
        n_fail++;
        end_sim();
    end
endmodule
`default_nettype wire
